// [hw/nvm_program_ctrl.sv]
// Programming control and status register of the on-chip data memory.
// Assumes a plain register port synchronous to clk_i and a memory array that
// pulses prog_done_i once when the cycle it was started for has finished.
`default_nettype none

module nvm_program_ctrl #(
  parameter logic [23:0] TIMEOUT_TICKS = 24'(nvm_prog_pkg::TIMEOUT_TICKS)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [nvm_prog_pkg::ADDR_W-1:0] addr_i,
  input wire logic [nvm_prog_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [nvm_prog_pkg::DATA_W-1:0] rdata_o,
  // Memory array side.
  output logic prog_start_o,
  output logic prog_active_o,
  output logic write_mode_o,
  input wire logic prog_done_i,
  // Interrupt.
  output logic irq_o
);

  // ***************************************************************
  // Declarations.
  // ***************************************************************
  nvm_prog_pkg::prog_state_t state_q;
  nvm_prog_pkg::prog_state_t state_d;
  logic latch_write_select_q;
  logic latch_write_select_d;
  logic start_pulse_q;
  logic [nvm_prog_pkg::DATA_W-1:0] rdata_d;
  logic [nvm_prog_pkg::DATA_W-1:0] ctrl_view;
  logic ctrl_wr;
  logic ctrl_rd;
  logic stat_rd;
  logic mask_wr;
  logic wr_pgm;
  logic wr_lat;
  logic running;
  logic start;
  logic sw_abort;
  logic timeout;
  logic cycle_end;
  logic [nvm_prog_pkg::IRQ_N-1:0] irq_set;
  logic [nvm_prog_pkg::IRQ_N-1:0] irq_stat;
  logic [nvm_prog_pkg::IRQ_N-1:0] irq_mask;

  // ***************************************************************
  // Address decode.
  // ***************************************************************
  assign ctrl_wr = wr_i && (addr_i == nvm_prog_pkg::OFF_CTRL);
  assign ctrl_rd = rd_i && (addr_i == nvm_prog_pkg::OFF_CTRL);
  assign stat_rd = rd_i && (addr_i == nvm_prog_pkg::OFF_IRQ_STAT);
  assign mask_wr = wr_i && (addr_i == nvm_prog_pkg::OFF_IRQ_MASK);

  // Only bits one and zero are looked at; the rest are dropped.
  assign wr_pgm = wdata_i[nvm_prog_pkg::BIT_PGM];
  assign wr_lat = wdata_i[nvm_prog_pkg::BIT_LAT];

  // ***************************************************************
  // Cycle events.
  // ***************************************************************
  assign running = (state_q == nvm_prog_pkg::ST_RUN);

  // The array's done pulse or the guard timer ends the cycle.
  assign cycle_end = running && (prog_done_i || timeout);

  // A one written to the program bit while idle starts a cycle.
  assign start = !running && ctrl_wr && wr_pgm;

  // Clearing the program bit mid-cycle stops it early; the array
  // contents are then left undefined, so it is flagged as an event.
  assign sw_abort = running && !cycle_end && ctrl_wr && !wr_pgm;

  // ***************************************************************
  // Program sequencer.
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      nvm_prog_pkg::ST_IDLE: begin
        if (start) begin
          state_d = nvm_prog_pkg::ST_RUN;
        end
      end
      nvm_prog_pkg::ST_RUN: begin
        if (cycle_end || sw_abort) begin
          state_d = nvm_prog_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = nvm_prog_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= nvm_prog_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // Latch write select.
  // ***************************************************************
  always_comb begin
    latch_write_select_d = latch_write_select_q;
    if (cycle_end) begin
      latch_write_select_d = 1'b0;
    end else if (ctrl_wr && wr_lat) begin
      latch_write_select_d = 1'b1;
    end else if (ctrl_wr && !running) begin
      latch_write_select_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_write_select_q <= nvm_prog_pkg::CTRL_RESET[nvm_prog_pkg::BIT_LAT];
    end else begin
      latch_write_select_q <= latch_write_select_d;
    end
  end

  // ***************************************************************
  // Memory array outputs.
  // ***************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_pulse_q <= 1'b0;
    end else begin
      start_pulse_q <= start;
    end
  end

  assign prog_start_o = start_pulse_q;
  assign prog_active_o = running;
  assign write_mode_o = latch_write_select_q;

  // ***************************************************************
  // Guard timer.
  // ***************************************************************
  prog_timeout #(
    .LIMIT_TICKS(TIMEOUT_TICKS)
  ) u_timeout (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(running),
    .expire_o(timeout)
  );

  // ***************************************************************
  // Interrupts.
  // ***************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[nvm_prog_pkg::IRQ_DONE] = cycle_end && prog_done_i;
    irq_set[nvm_prog_pkg::IRQ_ABORT] = sw_abort;
    irq_set[nvm_prog_pkg::IRQ_TIMEOUT] = cycle_end && !prog_done_i;
  end

  irq_unit #(
    .N(nvm_prog_pkg::IRQ_N)
  ) u_irq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .set_i(irq_set),
    .clr_i(stat_rd),
    .mask_wr_i(mask_wr),
    .mask_wdata_i(wdata_i[nvm_prog_pkg::IRQ_N-1:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ***************************************************************
  // Read data.
  // ***************************************************************
  always_comb begin
    ctrl_view = '0;
    ctrl_view[nvm_prog_pkg::BIT_LAT] = latch_write_select_q;
    ctrl_view[nvm_prog_pkg::BIT_PGM] = running;
  end

  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      case (addr_i)
        nvm_prog_pkg::OFF_CTRL: begin
          rdata_d = ctrl_view;
        end
        nvm_prog_pkg::OFF_IRQ_STAT: begin
          rdata_d = {{(nvm_prog_pkg::DATA_W - nvm_prog_pkg::IRQ_N){1'b0}}, irq_stat};
        end
        nvm_prog_pkg::OFF_IRQ_MASK: begin
          rdata_d = {{(nvm_prog_pkg::DATA_W - nvm_prog_pkg::IRQ_N){1'b0}}, irq_mask};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= nvm_prog_pkg::CTRL_RESET;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ***************************************************************
  // Checks.
  // ***************************************************************
  a_upper_zero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ctrl_rd |=> (rdata_o[7:2] == 6'h00))
    else $error("upper control bits read nonzero");

  a_latch_set: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (ctrl_wr && wr_lat && !cycle_end) |=> (latch_write_select_q && write_mode_o))
    else $error("write mode not selected after write");

  a_end_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cycle_end |=> (!latch_write_select_q && !prog_active_o))
    else $error("latch select kept after cycle end");

  a_latch_hold: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (ctrl_wr && !wr_lat && running && !cycle_end)
      |=> (latch_write_select_q == $past(latch_write_select_q)))
    else $error("latch select cleared during cycle");

  a_start_seq: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    start |=> (prog_start_o && prog_active_o) ##1 !prog_start_o)
    else $error("start did not launch one cycle");

  a_read_pgm: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ctrl_rd |=> (rdata_o[nvm_prog_pkg::BIT_PGM] == $past(running)))
    else $error("program bit reads wrong");

  a_abort_seen: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    sw_abort |=> (!prog_active_o && irq_stat[nvm_prog_pkg::IRQ_ABORT]))
    else $error("abort not handled");

  a_reset_zero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> (!latch_write_select_q && !running && !prog_start_o))
    else $error("control not zero after reset");

  a_drop_together: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $fell(prog_active_o) && $past(cycle_end) |-> $fell(write_mode_o) || !$past(write_mode_o))
    else $error("control bits did not drop together");

endmodule : nvm_program_ctrl

`default_nettype wire

// [hw/nvm_prog_pkg.sv]
// Constants, register map and types of the data memory programming control block.
// Assumes one 20 MHz clock and an 8-bit register port with byte addresses.
// Notes on behaviour
// - Bits seven down to two of the control register always read zero and ignore writes.
// - Control bit one selects read mode at zero and write mode at one, and software sets it.
// - Hardware clears control bit one when a programming cycle ends by done or timeout; a software abort leaves it set.
// - Software can clear control bit one only while no programming cycle runs.
// - Writing one to control bit zero starts a programming cycle.
// - Control bit zero reads one while a cycle runs and zero when finished or never started.
// - After reset the control register reads all zeros.
`default_nettype none

package nvm_prog_pkg;

  // ***************************************************************
  // Register port and map.
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_PGM = 0;
  localparam int BIT_LAT = 1;

  // ***************************************************************
  // Interrupt status and mask fields.
  // ***************************************************************
  localparam int IRQ_N = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam logic [2:0] IRQ_STAT_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ***************************************************************
  // Timing.
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_TIME_US = 10000;
  localparam int TIMEOUT_TICKS = (TIMEOUT_TIME_US * 1000) / TICK_TIME_NS;

  // ***************************************************************
  // Sequencer states.
  // ***************************************************************
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } prog_state_t;

endpackage : nvm_prog_pkg

`default_nettype wire

// [hw/prog_timeout.sv]
// Guard timer that ends a programming cycle the array never reports as done.
// Assumes run_i stays high for the whole cycle and drops right after expire_o.
`default_nettype none

module prog_timeout #(
  parameter logic [23:0] LIMIT_TICKS = 24'(nvm_prog_pkg::TIMEOUT_TICKS)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control and result.
  input wire logic run_i,
  output logic expire_o
);

  localparam logic [4:0] DIV_LAST = 5'(nvm_prog_pkg::TICK_CYCLES - 1);

  logic [4:0] div_q;
  logic [23:0] ticks_q;
  logic tick;

  // ***************************************************************
  // One microsecond enable and tick counter.
  // ***************************************************************
  assign tick = run_i && (div_q == DIV_LAST);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q <= 5'h0;
    end else if (!run_i || tick) begin
      div_q <= 5'h0;
    end else begin
      div_q <= div_q + 5'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ticks_q <= 24'h00_0000;
      expire_o <= 1'b0;
    end else if (!run_i) begin
      ticks_q <= 24'h00_0000;
      expire_o <= 1'b0;
    end else if (tick && (ticks_q == LIMIT_TICKS - 24'h00_0001)) begin
      ticks_q <= 24'h00_0000;
      expire_o <= 1'b1;
    end else begin
      ticks_q <= tick ? ticks_q + 24'h00_0001 : ticks_q;
      expire_o <= 1'b0;
    end
  end

  a_expire_single: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    expire_o |=> !expire_o)
    else $error("timeout pulse longer than one cycle");

endmodule : prog_timeout

`default_nettype wire

// [hw/irq_unit.sv]
// Sticky event flags with a mask and one level interrupt output.
// Assumes clr_i is a one-cycle pulse from a read of the status register.
`default_nettype none

module irq_unit #(
  parameter int N = nvm_prog_pkg::IRQ_N
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Events and register access.
  input wire logic [N-1:0] set_i,
  input wire logic clr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] mask_wdata_i,
  // State and interrupt.
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);

  // ***************************************************************
  // Flags; an event in the clearing cycle wins.
  // ***************************************************************
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        status_o[i] <= nvm_prog_pkg::IRQ_STAT_RESET[i];
      end else if (set_i[i]) begin
        status_o[i] <= 1'b1;
      end else if (clr_i) begin
        status_o[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_o <= nvm_prog_pkg::IRQ_MASK_RESET;
    end else if (mask_wr_i) begin
      mask_o <= mask_wdata_i;
    end
  end

  assign irq_o = |(status_o & mask_o);

  a_event_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (set_i != '0) |=> ((status_o & $past(set_i)) == $past(set_i)))
    else $error("event lost from status");

endmodule : irq_unit

`default_nettype wire

// [testbench/nvm_array_model.sv]
// Behavioural model of the data memory array behind the programming control block.
// Assumes prog_start_i is a one-cycle pulse and prog_active_i stays high while a cycle runs.
`default_nettype none

module nvm_array_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Cycle control from the block.
  input wire logic prog_start_i,
  input wire logic prog_active_i,
  input wire logic [7:0] delay_i,
  // Completion back to the block.
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // Completion after delay_i cycles; zero means the array stays silent.
  // ***************************************************************
  logic [7:0] cnt_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (prog_start_i) begin
        cnt_q <= delay_i;
      end else if (!prog_active_i) begin
        cnt_q <= 8'h00;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        done_o <= (cnt_q == 8'h01);
      end
    end
  end
endmodule : nvm_array_model

`default_nettype wire

// [testbench/test_nvm_program_ctrl.sv]
// Self-checking testbench of the data memory programming control block.
// Assumes the package and design files are compiled first, and a 20 MHz clock.
`default_nettype none

module test_nvm_program_ctrl;
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // Signals, clock and instances.
  // ***************************************************************
  localparam int TICKS = nvm_prog_pkg::TICK_CYCLES;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] delay = 8'h00;
  logic [7:0] rdata_o;
  logic prog_start_o;
  logic prog_active_o;
  logic write_mode_o;
  logic prog_done_i;
  logic irq_o;
  int bad_count = 0;
  int check_count = 0;

  always #25 clk_i = ~clk_i;

  nvm_program_ctrl #(.TIMEOUT_TICKS(24'h00_0003)) u_nvm_program_ctrl (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prog_start_o(prog_start_o),
    .prog_active_o(prog_active_o), .write_mode_o(write_mode_o),
    .prog_done_i(prog_done_i), .irq_o(irq_o));

  nvm_array_model u_nvm_array_model (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .prog_start_i(prog_start_o),
    .prog_active_i(prog_active_o), .delay_i(delay), .done_o(prog_done_i));

  // ***************************************************************
  // Access and comparison tasks.
  // ***************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : reg_rd

  // Waits for the cycle to end, then checks the mode bit just before and at the end.
  task automatic wait_idle(input int lim, input logic lat);
    int n;
    logic last;
    n = 0;
    last = write_mode_o;
    while (prog_active_o !== 1'b0 && n < lim) begin
      last = write_mode_o;
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("BAD t=%0t cycle never ended", $time);
      tally_and_finish();
    end else begin
      check({6'h00, last, write_mode_o}, {6'h00, lat, 1'b0});
    end
  endtask : wait_idle

  // ***************************************************************
  // Test sequence.
  // ***************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h00);
    check({7'h00, write_mode_o}, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_IRQ_STAT, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_IRQ_MASK, 8'h00);
    reg_rd(8'h30, 8'h00);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'hFE);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h02);
    check({7'h00, write_mode_o}, 8'h01);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h00);
    // Write-mode cycle ended by the array, interrupt enabled.
    delay <= 8'h14;
    reg_wr(nvm_prog_pkg::OFF_IRQ_MASK, 8'h07);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h03);
    check({7'h00, prog_start_o}, 8'h01);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h01);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h03);
    check({7'h00, prog_active_o}, 8'h01);
    wait_idle(40, 1'b1);
    check({7'h00, irq_o}, 8'h01);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_IRQ_STAT, 8'h01);
    check({7'h00, irq_o}, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_IRQ_STAT, 8'h00);
    // Read-mode cycle with a silent array ends by the guard timer, masked.
    delay <= 8'h00;
    reg_wr(nvm_prog_pkg::OFF_IRQ_MASK, 8'h00);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h01);
    repeat (2 * TICKS - 2) @(posedge clk_i);
    #1;
    check({6'h00, write_mode_o, prog_active_o}, 8'h01);
    wait_idle(2 * TICKS + 10, 1'b0);
    check({7'h00, irq_o}, 8'h00);
    reg_rd(nvm_prog_pkg::OFF_IRQ_STAT, 8'h04);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h00);
    // Write-mode cycle stopped by software, abort interrupt enabled.
    reg_wr(nvm_prog_pkg::OFF_IRQ_MASK, 8'h02);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h03);
    reg_wr(nvm_prog_pkg::OFF_CTRL, 8'h00);
    check({6'h00, write_mode_o, prog_active_o}, 8'h02);
    check({7'h00, irq_o}, 8'h01);
    reg_rd(nvm_prog_pkg::OFF_CTRL, 8'h02);
    reg_rd(nvm_prog_pkg::OFF_IRQ_STAT, 8'h02);
    check({7'h00, irq_o}, 8'h00);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    $display("BAD t=%0t run did not finish", $time);
    tally_and_finish();
  end
endmodule : test_nvm_program_ctrl

`default_nettype wire
